//--- shared/scg_defines.vh
// Constants for the serial configuration write and gain block
// Operation
// - Frame is 4 address bits, two dummy bits, then 10 data bits.
// - Write counts only with at least 16 strobe-gated clock rises.
// - Strobe rising edge captures the latest 16 shifted bits.
// - Address selects a register; its whole content becomes the data.
// - Serial clock rises outside an active strobe shift nothing.
// - Shifted bits are held indefinitely until the committing strobe edge.
// - Red, green and blue gain codes are separate, each for its channel.
// - Gain codes are 9 bits; gain rises monotonically from 0 to 511.
// - Range select clear gives 1x to 5x, set gives 1.5x to 7.5x.
// - Gain is 4*code/511+1 low range, 6.0*code/511+1.5 high range.
// - Writing one to reset bit D9 restores every register default.
// - Readback pointer selects register shown when readback enable set.
`ifndef SCG_DEFINES_VH
`define SCG_DEFINES_VH
`define SCG_FRAME_BITS     5'd16
`define SCG_ADDR_MSB       15
`define SCG_ADDR_LSB       12
`define SCG_DATA_MSB       9
`define SCG_DATA_LSB       0
`define SCG_ADDR_MODE      4'h0
`define SCG_ADDR_RED_GAIN  4'h1
`define SCG_ADDR_GRN_GAIN  4'h2
`define SCG_ADDR_BLU_GAIN  4'h3
`define SCG_ADDR_RESET_RB  4'hf
`define SCG_BIT_RANGE_SEL  0
`define SCG_BIT_RESET      9
`define SCG_BIT_RB_ENABLE  8
`define SCG_RB_PTR_MSB     3
`define SCG_RB_PTR_LSB     0
`define SCG_REG_DEFAULT    10'h000
`define SCG_GAIN_DIV       20'd511
`define SCG_LOW_SLOPE      11'd1024
`define SCG_LOW_BASE       12'd256
`define SCG_HIGH_SLOPE     11'd1536
`define SCG_HIGH_BASE      12'd384
`endif

//--- logic/scg_serial_config.v
// Serial configuration port, register file and channel gain values
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "scg_defines.vh"

module scg_pin_sync
#(
	parameter RESET_LEVEL = 1'b0
)
(
	input  wire clock_in,
	input  wire rst_in,
	input  wire pin_in,
	output reg  level_out,
	output reg  delayed_out
);
	// First stage may be metastable; only its follower is read
	reg stage;

	always @(posedge clock_in)
	begin
		if (rst_in)
		begin
			stage       <= RESET_LEVEL;
			level_out   <= RESET_LEVEL;
			delayed_out <= RESET_LEVEL;
		end
		else
		begin
			stage       <= pin_in;
			level_out   <= stage;
			delayed_out <= level_out;
		end
	end
endmodule // scg_pin_sync

module scg_gain_calc
(
	input  wire       clock_in,
	input  wire       rst_in,
	input  wire [8:0] code_in,
	input  wire       range_in,
	output reg  [11:0] gain_q8_out
);
	wire [10:0] slope;
	wire [11:0] base;
	wire [19:0] prod;
	wire [19:0] quot;

	assign slope = range_in ? `SCG_HIGH_SLOPE : `SCG_LOW_SLOPE;
	assign base  = range_in ? `SCG_HIGH_BASE : `SCG_LOW_BASE;
	assign prod  = {11'h000, code_in} * {9'h000, slope};
	// Constant divisor keeps the curve exact; costs a divider per channel
	assign quot  = prod / `SCG_GAIN_DIV;

	always @(posedge clock_in)
	begin
		if (rst_in)
			gain_q8_out <= `SCG_LOW_BASE;
		else
			gain_q8_out <= base + quot[11:0];
	end
endmodule // scg_gain_calc

module scg_serial_config
(
	input  wire        clock_in,
	input  wire        rst_in,
	input  wire        frame_strobe_n_in,
	input  wire        serial_clock_in,
	input  wire        serial_data_in,
	input  wire [3:0]  addr_in,
	input  wire [9:0]  wr_data_in,
	input  wire        wr_strobe_in,
	input  wire        rd_strobe_in,
	output reg  [9:0]  rd_data_out,
	output reg  [8:0]  red_gain_out,
	output reg  [8:0]  green_gain_out,
	output reg  [8:0]  blue_gain_out,
	output reg         gain_range_select_out,
	output wire [11:0] red_gain_q8_out,
	output wire [11:0] green_gain_q8_out,
	output wire [11:0] blue_gain_q8_out,
	output reg         readback_enable_out,
	output reg  [9:0]  readback_data_out,
	output reg         commit_pulse_out
);
	localparam FRAME_IDLE  = 3'b001;
	localparam FRAME_SHIFT = 3'b010;
	localparam FRAME_FULL  = 3'b100;

	wire        strobe_level;
	wire        strobe_prev;
	wire        sclk_level;
	wire        sclk_prev;
	wire        sdi_level;
	reg  [2:0]  frame_state;
	reg  [2:0]  next_frame_state;
	reg  [15:0] shift;
	reg  [4:0]  edge_count;
	reg  [9:0]  regs [0:15];
	reg  [3:0]  commit_addr;
	reg  [9:0]  commit_data;
	reg         commit;
	reg         soft_reset;
	reg  [3:0]  next_addr;
	reg  [9:0]  next_data;
	reg         next_write;
	integer     i;

	wire strobe_active = ~strobe_level;
	wire strobe_rise   = strobe_level & ~strobe_prev;
	wire strobe_fall   = ~strobe_level & strobe_prev;
	wire sclk_rise     = sclk_level & ~sclk_prev;
	wire frame_full    = (frame_state == FRAME_FULL);
	wire [9:0] mode_reg  = regs[`SCG_ADDR_MODE];
	wire [9:0] rb_reg    = regs[`SCG_ADDR_RESET_RB];

	// Pins cross domains; logic reads the second and third stages, never the first
	scg_pin_sync #(.RESET_LEVEL(1'b1)) u_strobe_sync
	(
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.pin_in      (frame_strobe_n_in),
		.level_out   (strobe_level),
		.delayed_out (strobe_prev)
	);

	scg_pin_sync #(.RESET_LEVEL(1'b0)) u_sclk_sync
	(
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.pin_in      (serial_clock_in),
		.level_out   (sclk_level),
		.delayed_out (sclk_prev)
	);

	// Data needs no edge detect, so its delayed copy is unused
	scg_pin_sync #(.RESET_LEVEL(1'b0)) u_sdi_sync
	(
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.pin_in      (serial_data_in),
		.level_out   (sdi_level),
		.delayed_out ()
	);

	// Short frames fall back to idle and are thrown away
	always @*
	begin
		next_frame_state = frame_state;
		case (frame_state)
			FRAME_IDLE:
				if (strobe_fall)
					next_frame_state = FRAME_SHIFT;
			FRAME_SHIFT:
				if (strobe_rise)
					next_frame_state = FRAME_IDLE;
				else if (strobe_active && sclk_rise && edge_count == (`SCG_FRAME_BITS - 5'h01))
					next_frame_state = FRAME_FULL;
			FRAME_FULL:
				if (strobe_rise)
					next_frame_state = FRAME_IDLE;
			default:
				next_frame_state = FRAME_IDLE;
		endcase
	end

	always @(posedge clock_in)
	begin
		if (rst_in)
			frame_state <= FRAME_IDLE;
		else
			frame_state <= next_frame_state;
	end

	// Strobe fall starts a frame; the count saturates at a full frame
	always @(posedge clock_in)
	begin
		if (rst_in)
			edge_count <= 5'h00;
		else if (strobe_fall)
			edge_count <= 5'h00;
		else if (strobe_active && sclk_rise && edge_count != `SCG_FRAME_BITS)
			edge_count <= edge_count + 5'h01;
	end

	// Shifter; no timer, so bits wait as long as the host likes
	always @(posedge clock_in)
	begin
		if (rst_in)
			shift <= 16'h0000;
		else if (strobe_active && sclk_rise && !strobe_fall)
			shift <= {shift[14:0], sdi_level};
	end

	// Extra rises push old bits out, so the last 16 are kept
	always @(posedge clock_in)
	begin
		if (rst_in)
		begin
			commit      <= 1'b0;
			commit_addr <= 4'h0;
			commit_data <= 10'h000;
		end
		else
		begin
			commit <= strobe_rise && frame_full;
			if (strobe_rise && frame_full)
			begin
				commit_addr <= shift[`SCG_ADDR_MSB:`SCG_ADDR_LSB];
				commit_data <= shift[`SCG_DATA_MSB:`SCG_DATA_LSB];
			end
		end
	end

	// Serial commit wins over a bus write in the same cycle
	always @*
	begin
		next_write = commit | wr_strobe_in;
		next_addr  = commit ? commit_addr : addr_in;
		next_data  = commit ? commit_data : wr_data_in;
	end

	always @(posedge clock_in)
	begin
		if (rst_in || soft_reset)
		begin
			for (i = 0; i < 16; i = i + 1)
				regs[i] <= `SCG_REG_DEFAULT;
			soft_reset <= 1'b0;
		end
		else
		begin
			soft_reset <= 1'b0;
			if (next_write)
			begin
				if (next_addr == `SCG_ADDR_RESET_RB && next_data[`SCG_BIT_RESET])
					soft_reset <= 1'b1;
				else
					regs[next_addr] <= next_data;
			end
		end
	end

	// Read data stands one cycle, then drops back to zero
	always @(posedge clock_in)
	begin
		if (rst_in)
			rd_data_out <= 10'h000;
		else
			rd_data_out <= rd_strobe_in ? regs[addr_in] : 10'h000;
	end

	always @(posedge clock_in)
	begin
		if (rst_in)
		begin
			red_gain_out          <= 9'h000;
			green_gain_out        <= 9'h000;
			blue_gain_out         <= 9'h000;
			gain_range_select_out <= 1'b0;
		end
		else
		begin
			red_gain_out          <= regs[`SCG_ADDR_RED_GAIN][8:0];
			green_gain_out        <= regs[`SCG_ADDR_GRN_GAIN][8:0];
			blue_gain_out         <= regs[`SCG_ADDR_BLU_GAIN][8:0];
			gain_range_select_out <= mode_reg[`SCG_BIT_RANGE_SEL];
		end
	end

	always @(posedge clock_in)
	begin
		if (rst_in)
		begin
			readback_enable_out <= 1'b0;
			readback_data_out   <= 10'h000;
			commit_pulse_out    <= 1'b0;
		end
		else
		begin
			readback_enable_out <= rb_reg[`SCG_BIT_RB_ENABLE];
			readback_data_out   <= rb_reg[`SCG_BIT_RB_ENABLE] ?
				regs[rb_reg[`SCG_RB_PTR_MSB:`SCG_RB_PTR_LSB]] : 10'h000;
			commit_pulse_out    <= commit;
		end
	end

	scg_gain_calc u_red
	(
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.code_in     (red_gain_out),
		.range_in    (gain_range_select_out),
		.gain_q8_out (red_gain_q8_out)
	);

	scg_gain_calc u_green
	(
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.code_in     (green_gain_out),
		.range_in    (gain_range_select_out),
		.gain_q8_out (green_gain_q8_out)
	);

	scg_gain_calc u_blue
	(
		.clock_in    (clock_in),
		.rst_in      (rst_in),
		.code_in     (blue_gain_out),
		.range_in    (gain_range_select_out),
		.gain_q8_out (blue_gain_q8_out)
	);
endmodule // scg_serial_config
`default_nettype wire

//--- tb/scg_serial_config_sva.sv
// Port assertions for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
module scg_serial_config_sva
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic frame_strobe_n_in,
	input wire logic wr_strobe_in,
	input wire logic commit_pulse_out,
	input wire logic gain_range_select_out,
	input wire logic readback_enable_out,
	input wire logic [8:0] red_gain_out,
	input wire logic [8:0] blue_gain_out,
	input wire logic [11:0] red_gain_q8_out,
	input wire logic [11:0] blue_gain_q8_out,
	input wire logic [9:0] readback_data_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (rst_in);
	function automatic int g(input logic [8:0] c, input logic r);
		return r ? 384 + c * 1536 / 511 : 256 + c * 1024 / 511;
	endfunction
	property p_cp; commit_pulse_out |=> !commit_pulse_out; endproperty
	a_cp: assert property (p_cp) else $error("long commit");
	property p_cs;
		commit_pulse_out |-> $past(frame_strobe_n_in, 2) && !$past(frame_strobe_n_in, 8);
	endproperty
	a_cs: assert property (p_cs) else $error("stray commit");
	property p_rq; !$past(rst_in) |->
		red_gain_q8_out == g($past(red_gain_out), $past(gain_range_select_out));
	endproperty
	a_rq: assert property (p_rq) else $error("red gain");
	property p_bq; !$past(rst_in) |->
		blue_gain_q8_out == g($past(blue_gain_out), $past(gain_range_select_out));
	endproperty
	a_bq: assert property (p_bq) else $error("blue gain");
	property p_ch; $changed(red_gain_out) |-> $past(commit_pulse_out) ||
		$past(commit_pulse_out, 2) || $past(wr_strobe_in, 2) || $past(wr_strobe_in, 3);
	endproperty
	a_ch: assert property (p_ch) else $error("code moved");
	property p_gs; $changed(gain_range_select_out) |-> $past(commit_pulse_out) ||
		$past(commit_pulse_out, 2) || $past(wr_strobe_in, 2) || $past(wr_strobe_in, 3);
	endproperty
	a_gs: assert property (p_gs) else $error("range moved");
	property p_re; $changed(readback_enable_out) |-> $past(commit_pulse_out) ||
		$past(commit_pulse_out, 2) || $past(wr_strobe_in, 2) || $past(wr_strobe_in, 3);
	endproperty
	a_re: assert property (p_re) else $error("enable moved");
	property p_rb; !readback_enable_out |-> readback_data_out == 10'h000; endproperty
	a_rb: assert property (p_rb) else $error("readback");
	c_cm: cover property (commit_pulse_out);
	c_hi: cover property (gain_range_select_out && red_gain_out == 9'h1ff);
	c_rb: cover property (readback_enable_out);
endmodule // scg_serial_config_sva
bind scg_serial_config scg_serial_config_sva scg_serial_config_sva_inst (.*);
`default_nettype wire

//--- tb/scg_host.sv
// Host controller model driving serial configuration frames
`timescale 1ns/1ps
`default_nettype none
module scg_host
(
	output var logic strobe_n_out,
	output var logic sclk_out,
	output var logic sdi_out
);
	initial {strobe_n_out, sclk_out, sdi_out} = 3'b100;
	// Clock idles low; g low leaves strobe high on purpose
	// Non-blocking updates, so a coinciding clock edge sees the old level
	task automatic send(input logic [15:0] f, input int n, input logic g, input int hold);
		strobe_n_out <= !g;
		#300;
		for (int i = n - 1; i >= 0; i--)
		begin
			sdi_out <= (i < 16) ? f[i] : !f[15];
			#100 sclk_out <= 1;
			#200 sclk_out <= 0;
			#100;
		end
		sdi_out <= !sdi_out;
		#(hold + 300) strobe_n_out <= 1;
	endtask
endmodule // scg_host
`default_nettype wire

//--- tb/scg_serial_config_tb.sv
// Self-checking bench for the serial configuration block
`timescale 1ns/1ps
`default_nettype none
module scg_serial_config_tb;
	logic clock_in = 0, rst_in = 1, wr_strobe_in = 0, rd_strobe_in = 0;
	logic frame_strobe_n_in, serial_clock_in, serial_data_in;
	logic gain_range_select_out, readback_enable_out, commit_pulse_out;
	logic [3:0] addr_in = 0;
	logic [9:0] wr_data_in = 0, rd_data_out, readback_data_out, d;
	logic [8:0] red_gain_out, green_gain_out, blue_gain_out, c;
	logic [11:0] red_gain_q8_out, green_gain_q8_out, blue_gain_q8_out;
	int fails = 0, n_checks = 0, cyc = 0;
	scg_serial_config scg_serial_config_inst (.*);
	scg_host scg_host_inst (.strobe_n_out(frame_strobe_n_in), .sclk_out(serial_clock_in),
		.sdi_out(serial_data_in));
	always #25 clock_in = ~clock_in;
	always @(posedge clock_in)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			conclude();
		end
	end
	task conclude;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task wr(input logic [3:0] a, input logic [9:0] v);
		@(posedge clock_in);
		addr_in <= a;
		wr_data_in <= v;
		wr_strobe_in <= 1;
		@(posedge clock_in);
		wr_strobe_in <= 0;
	endtask
	task rd(input logic [3:0] a, input logic [9:0] v);
		@(posedge clock_in);
		addr_in <= a;
		rd_strobe_in <= 1;
		@(posedge clock_in);
		rd_strobe_in <= 0;
		@(negedge clock_in) chk(rd_data_out === v, "read");
		@(negedge clock_in) chk(rd_data_out === 10'h000, "read idle");
	endtask
	task wc(input logic e);
		logic s;
		s = 0;
		repeat (30) @(negedge clock_in) s |= commit_pulse_out;
		chk(s === e, "commit");
	endtask
	function logic [11:0] q8(input logic [8:0] v, input logic r);
		return r ? 12'(384 + v * 1536 / 511) : 12'(256 + v * 1024 / 511);
	endfunction
	initial
	begin
		void'($urandom(86));
		repeat (2) @(posedge clock_in);
		rst_in <= 0;
		for (int i = 0; i < 6; i++)
		begin
			c = (i < 2) ? 9'h000 : (i < 4) ? 9'h1ff : 9'($urandom);
			wr(4'h0, {9'h000, i[0]});
			wr(4'h1, {1'b1, c});
			wr(4'h2, {1'b0, ~c});
			wr(4'h3, {1'b0, c ^ 9'h0aa});
			repeat (5) @(posedge clock_in);
			@(negedge clock_in);
			chk({red_gain_out, green_gain_out} === {c, ~c}, "code");
			chk(red_gain_q8_out === q8(c, i[0]), "red q8");
			chk(green_gain_q8_out === q8(~c, i[0]), "green q8");
			rd(4'h1, {1'b1, c});
		end
		d = 10'($urandom);
		scg_host_inst.send({4'h1, 2'b00, d}, 16, 1, 0);
		wc(1);
		chk(red_gain_out === d[8:0], "serial");
		scg_host_inst.send({4'h2, 2'b00, ~d}, 19, 1, 5000);
		wc(1);
		chk(green_gain_out === ~d[8:0], "last bits");
		scg_host_inst.send({4'h3, 2'b00, d}, 15, 1, 0);
		wc(0);
		scg_host_inst.send({4'h3, 2'b00, d}, 16, 0, 0);
		wc(0);
		chk(blue_gain_out === (c ^ 9'h0aa), "kept");
		wr(4'hf, 10'h101);
		repeat (3) @(posedge clock_in);
		@(negedge clock_in);
		chk({readback_enable_out, readback_data_out} === {1'b1, d}, "readback");
		scg_host_inst.send(16'hf200, 16, 1, 0);
		wc(1);
		chk({red_gain_out, blue_gain_out, gain_range_select_out} === 19'h0, "soft");
		rd(4'h1, 10'h000);
		conclude();
	end
endmodule // scg_serial_config_tb
`default_nettype wire
